// file: common/btic_consts.svh
`ifndef BTIC_CONSTS_SVH
`define BTIC_CONSTS_SVH
`define BTIC_CFG1_ADDR 8'h01
`define BTIC_MASK_ADDR 8'h02
`define BTIC_STAT_ADDR 8'h03
`define BTIC_CTRL_ADDR 8'h04
`define BTIC_CFG1_RST 16'h0000
`define BTIC_CFG1_RW_MASK 16'hfff8
`define BTIC_MS_HI 15
`define BTIC_MS_LO 14
`define BTIC_AREA 13
`define BTIC_EN_FLAG 2
`define BTIC_IRQ_TTAG 6
`define BTIC_IRQ_CBUF 5
`define BTIC_IRQ_CWEOM 4
`define BTIC_IRQ_FRAME 3
`define BTIC_IRQ_FMT 2
`define BTIC_IRQ_SSET 1
`define BTIC_IRQ_EOM 0
`define BTIC_NRT_18P5_NS 18500
`define BTIC_NRT_22P5_NS 22500
`define BTIC_NRT_50P5_NS 50500
`define BTIC_NRT_130_NS 130000
`define BTIC_CLK_NS 8
`endif

// file: common/btic_pkg.sv
package btic_pkg;
  typedef enum logic [1:0] {
    BTIC_MODE_BC = 2'b00,
    BTIC_MODE_MT = 2'b01,
    BTIC_MODE_RT = 2'b10,
    BTIC_MODE_IDLE = 2'b11
  } btic_mode_t;
  typedef struct packed {
    logic msg_end;
    logic msg_err;
    logic msg_rx;
    logic cbuf_bottom;
    logic cbuf_roll_en;
    logic sa_eom_en;
    logic bc_cw_eom;
    logic [15:0] msg_count;
    logic bc_abort;
    logic frame_timer_zero;
    logic cmd_invalid;
    logic mode_code_en;
    logic cmd_valid;
    logic [15:0] cmd_word;
  } btic_msg_t;
  typedef struct packed {
    logic tx_word;
    logic [15:0] tx_data;
    logic echo_word;
    logic echo_valid;
    logic [15:0] echo_data;
    logic last_word;
  } btic_loop_t;
  typedef struct packed {
    logic sts_valid;
    logic [4:0] sts_addr;
    logic [7:0] sts_bits;
    logic bcst_mask;
  } btic_sts_t;
endpackage : btic_pkg

// file: core/btic_resp_timer.sv
`timescale 1ns/100ps
`include "btic_consts.svh"
module btic_resp_timer #(
  parameter int CW = 15
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [1:0] i_sel,
  output logic o_timeout
);
  localparam logic [CW-1:0] T0 = CW'(`BTIC_NRT_18P5_NS / `BTIC_CLK_NS);
  localparam logic [CW-1:0] T1 = CW'(`BTIC_NRT_22P5_NS / `BTIC_CLK_NS);
  localparam logic [CW-1:0] T2 = CW'(`BTIC_NRT_50P5_NS / `BTIC_CLK_NS);
  localparam logic [CW-1:0] T3 = CW'(`BTIC_NRT_130_NS / `BTIC_CLK_NS);
  logic [CW-1:0] cnt_q, cnt_d, lim;
  logic run_q, run_d, to_d;
  always_comb begin
    case (i_sel)
      2'b00: lim = T0;
      2'b01: lim = T1;
      2'b10: lim = T2;
      default: lim = T3;
    endcase
  end
  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    to_d = 1'b0;
    if (i_start) begin
      run_d = 1'b1;
      cnt_d = '0;
    end else if (i_stop) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q >= lim - 1'b1) begin
        run_d = 1'b0;
        to_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      o_timeout <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      o_timeout <= to_d;
    end
  end
endmodule : btic_resp_timer

// file: core/btic_loopback.sv
`timescale 1ns/100ps
module btic_loopback (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_msg_end,
  input wire btic_pkg::btic_loop_t i_loop,
  output logic o_fail
);
  logic bad_q, bad_d, fail_d;
  logic [15:0] last_q, last_d;
  always_comb begin
    bad_d = bad_q;
    last_d = last_q;
    fail_d = 1'b0;
    if (i_loop.tx_word) last_d = i_loop.tx_data;
    if (i_loop.echo_word) begin
      if (!i_loop.echo_valid) bad_d = 1'b1;
      if (i_loop.last_word && i_loop.echo_data != last_d) bad_d = 1'b1;
    end
    if (i_msg_end) begin
      fail_d = bad_d;
      bad_d = 1'b0;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bad_q <= 1'b0;
      last_q <= 16'h0000;
      o_fail <= 1'b0;
    end else begin
      bad_q <= bad_d;
      last_q <= last_d;
      o_fail <= fail_d;
    end
  end
endmodule : btic_loopback

// file: core/btic_top.sv
// Summary of operation
// - time tag wrap sets bit 6
// - rollover needs enhanced RT, enable, boundary
// - overwrite off: rollover right after bottom word
// - overwrite on: rollover at message end
// - overwrite on: no rollover on errored receive
// - bc control word eom needs expanded option
// - rt eom needs enhanced memory and flag
// - non-enhanced bc frame end at count ffff
// - aborted frame gives no frame end
// - enhanced bc: frame timer zero on bit 3
// - loopback failure flags format error
// - message errors flag; bad rt command ignored
// - bc/monitor no-response timeout, four choices
// - rt-to-rt status timeout flags format error
// - bc status set on address or bits
// - broadcast mask flips expected broadcast bit
// - rt mode code interrupt needs enables
// - word monitor pattern trigger on match
// - message end sets bit 0 in bc and rt; in monitor only with config bit 12
// - config one readable writable, mode, area
// - bc layout bits 12..3, bit 2 read-only
// - rt layout without alternate status
// - alternate status and monitor layouts
// - irq only for mask bits set
// - mode bits reset to zero
`timescale 1ns/100ps
`include "btic_consts.svh"
module btic_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_enhanced,
  input wire logic i_enh_mem_rt,
  input wire logic i_discard_bad_receive_data,
  input wire logic i_wide_controller_word_en,
  input wire logic i_frame_timer_irq_en,
  input wire logic i_bcst_mask_xor_n,
  input wire logic i_mode_code_handling,
  input wire logic [1:0] i_nrt_sel,
  input wire logic i_alt_status,
  input wire logic i_ttag_tick,
  input wire btic_pkg::btic_msg_t i_msg,
  input wire btic_pkg::btic_loop_t i_loop,
  input wire btic_pkg::btic_sts_t i_sts,
  input wire logic [4:0] i_rt_addr,
  input wire logic [15:0] i_trigger_word,
  input wire logic i_resp_start,
  input wire logic i_resp_seen,
  input wire logic i_ctrl_active,
  output btic_pkg::btic_mode_t o_mode,
  output logic o_area_b,
  output logic [6:0] o_status,
  output logic o_irq
);
  logic [15:0] cfg_q, cfg_d, ttag_q, ttag_d;
  logic [6:0] mask_q, mask_d, stat_q, stat_d, ev;
  logic [15:0] rdata_d;
  logic roll_pend_q, roll_pend_d, area_pend_q, area_pend_d;
  logic loop_fail, resp_to, area_val_q, area_val_d, busy;
  logic [7:0] exp_sts;
  btic_pkg::btic_mode_t mode;

  assign mode = btic_pkg::btic_mode_t'(cfg_q[`BTIC_MS_HI:`BTIC_MS_LO]);
  assign busy = i_ctrl_active;

  btic_loopback u_loop (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_msg_end(i_msg.msg_end),
    .i_loop(i_loop),
    .o_fail(loop_fail)
  );

  btic_resp_timer #(.CW(15)) u_resp (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(i_resp_start),
    .i_stop(i_resp_seen),
    .i_sel(i_nrt_sel),
    .o_timeout(resp_to)
  );

  // expected status bits; only broadcast-received (bit 4 of the eight) may be one
  always_comb begin
    exp_sts = 8'h00;
    if ((!i_enhanced || !i_bcst_mask_xor_n) && i_sts.bcst_mask)
      exp_sts[4] = 1'b1;
  end

  always_comb begin
    ev = 7'h00;
    ttag_d = ttag_q;
    roll_pend_d = roll_pend_q;
    if (i_ttag_tick) begin
      ttag_d = ttag_q + 16'h0001;
      ev[`BTIC_IRQ_TTAG] = (ttag_q == 16'hffff);
    end
    if (mode == btic_pkg::BTIC_MODE_RT && i_enh_mem_rt && i_msg.cbuf_roll_en
        && i_msg.cbuf_bottom) begin
      if (!i_discard_bad_receive_data) ev[`BTIC_IRQ_CBUF] = 1'b1;
      else roll_pend_d = 1'b1;
    end
    if (i_msg.msg_end) begin
      if (roll_pend_d && !(i_msg.msg_rx && i_msg.msg_err))
        ev[`BTIC_IRQ_CBUF] = 1'b1;
      roll_pend_d = 1'b0;
    end
    if (i_msg.msg_end && !(mode == btic_pkg::BTIC_MODE_RT && i_msg.cmd_invalid)) begin
      case (mode)
        btic_pkg::BTIC_MODE_BC: begin
          ev[`BTIC_IRQ_CWEOM] = i_wide_controller_word_en && i_msg.bc_cw_eom;
          ev[`BTIC_IRQ_FRAME] = !i_enhanced && i_msg.msg_count == 16'hffff
                                && !i_msg.bc_abort;
          ev[`BTIC_IRQ_EOM] = 1'b1;
        end
        btic_pkg::BTIC_MODE_RT: begin
          ev[`BTIC_IRQ_CWEOM] = i_enh_mem_rt && i_msg.sa_eom_en;
          ev[`BTIC_IRQ_SSET] = i_enhanced && i_mode_code_handling
                               && i_msg.mode_code_en;
          ev[`BTIC_IRQ_EOM] = 1'b1;
        end
        btic_pkg::BTIC_MODE_MT: ev[`BTIC_IRQ_EOM] = cfg_q[12];
        default: ev[`BTIC_IRQ_EOM] = 1'b0;
      endcase
      // bad rt command: message dropped silently
      if (i_msg.msg_err && !(mode == btic_pkg::BTIC_MODE_RT && i_msg.cmd_invalid))
        ev[`BTIC_IRQ_FMT] = 1'b1;
    end
    if (mode == btic_pkg::BTIC_MODE_BC && i_enhanced && i_frame_timer_irq_en
        && i_msg.frame_timer_zero)
      ev[`BTIC_IRQ_FRAME] = 1'b1;
    if (loop_fail && (mode == btic_pkg::BTIC_MODE_BC || mode == btic_pkg::BTIC_MODE_RT))
      ev[`BTIC_IRQ_FMT] = 1'b1;
    if (resp_to && mode != btic_pkg::BTIC_MODE_IDLE)
      ev[`BTIC_IRQ_FMT] = 1'b1;
    if (mode == btic_pkg::BTIC_MODE_BC && i_sts.sts_valid
        && (i_sts.sts_addr != i_rt_addr || i_sts.sts_bits != exp_sts))
      ev[`BTIC_IRQ_SSET] = 1'b1;
    if (mode == btic_pkg::BTIC_MODE_MT && !cfg_q[12] && i_enhanced && i_msg.cmd_valid
        && i_msg.cmd_word == i_trigger_word)
      ev[`BTIC_IRQ_SSET] = 1'b1;
  end

  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    stat_d = stat_q;
    area_pend_d = area_pend_q;
    area_val_d = area_val_q;
    if (i_wr && i_addr == `BTIC_CFG1_ADDR) begin
      cfg_d = i_wdata & `BTIC_CFG1_RW_MASK;
      // alternate status: bit 2 is status_bit_one, a stored bit, not a live flag
      if (i_wdata[15:14] == 2'b10 && i_alt_status && i_enhanced)
        cfg_d[`BTIC_EN_FLAG] = i_wdata[`BTIC_EN_FLAG];
      if (busy) begin
        cfg_d[`BTIC_AREA] = cfg_q[`BTIC_AREA];
        area_pend_d = 1'b1;
        area_val_d = i_wdata[`BTIC_AREA];
      end
    end
    // area change waits for the frame or message to finish
    if (area_pend_q && !busy) begin
      cfg_d[`BTIC_AREA] = area_val_q;
      area_pend_d = 1'b0;
    end
    if (i_wr && i_addr == `BTIC_MASK_ADDR) mask_d = i_wdata[6:0];
    // write one to clear; a same-cycle event wins
    if (i_wr && i_addr == `BTIC_STAT_ADDR) stat_d = stat_q & ~i_wdata[6:0];
    stat_d = stat_d | ev;
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `BTIC_CFG1_ADDR: begin
          rdata_d = cfg_q;
          if (mode == btic_pkg::BTIC_MODE_BC || mode == btic_pkg::BTIC_MODE_MT)
            rdata_d[`BTIC_EN_FLAG] = busy;
        end
        `BTIC_MASK_ADDR: rdata_d = {9'h000, mask_q};
        `BTIC_STAT_ADDR: rdata_d = {9'h000, stat_q};
        `BTIC_CTRL_ADDR: rdata_d = ttag_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= `BTIC_CFG1_RST;
      mask_q <= 7'h00;
      stat_q <= 7'h00;
      ttag_q <= 16'h0000;
      roll_pend_q <= 1'b0;
      area_pend_q <= 1'b0;
      area_val_q <= 1'b0;
      o_rdata <= 16'h0000;
      o_irq <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      ttag_q <= ttag_d;
      roll_pend_q <= roll_pend_d;
      area_pend_q <= area_pend_d;
      area_val_q <= area_val_d;
      o_rdata <= rdata_d;
      o_irq <= |(stat_d & mask_d);
    end
  end

  assign o_mode = mode;
  assign o_area_b = cfg_q[`BTIC_AREA];
  assign o_status = stat_q;

  property p_ttag_wrap;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ttag_tick && ttag_q == 16'hffff) |=> stat_q[`BTIC_IRQ_TTAG];
  endproperty
  a_ttag_wrap: assert property (p_ttag_wrap) else $error("wrap lost");
  property p_irq_mask;
    @(posedge i_mclk) disable iff (!i_rst_n) o_irq |-> |($past(stat_d) & $past(mask_d));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
  property p_eom;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && mode == btic_pkg::BTIC_MODE_BC) |=> stat_q[`BTIC_IRQ_EOM];
  endproperty
  a_eom: assert property (p_eom) else $error("eom lost");
  property p_cw_eom;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_BC && !i_wide_controller_word_en && stat_q == 7'h00
       && !(i_wr && i_addr == `BTIC_CFG1_ADDR)) |=> !stat_q[`BTIC_IRQ_CWEOM];
  endproperty
  a_cw_eom: assert property (p_cw_eom) else $error("cw eom without option");
  property p_abort;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && i_msg.bc_abort && !i_msg.frame_timer_zero) |-> !ev[`BTIC_IRQ_FRAME];
  endproperty
  a_abort: assert property (p_abort) else $error("frame end after abort");
  property p_roll_err;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_discard_bad_receive_data && i_msg.msg_end && i_msg.msg_rx && i_msg.msg_err)
      |-> !ev[`BTIC_IRQ_CBUF];
  endproperty
  a_roll_err: assert property (p_roll_err) else $error("rollover on bad rx");
  property p_clear_sticky;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (stat_q[0] && !(i_wr && i_addr == `BTIC_STAT_ADDR)) |=> stat_q[0];
  endproperty
  a_clear_sticky: assert property (p_clear_sticky) else $error("bit lost");
  property p_rdata;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && i_addr == `BTIC_MASK_ADDR) |=> o_rdata == {9'h000, $past(mask_q)};
  endproperty
  a_rdata: assert property (p_rdata) else $error("mask read wrong");
  property p_roll_now;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_RT && i_enh_mem_rt && i_msg.cbuf_roll_en
       && i_msg.cbuf_bottom && !i_discard_bad_receive_data) |=> stat_q[`BTIC_IRQ_CBUF];
  endproperty
  a_roll_now: assert property (p_roll_now) else $error("rollover late");
  property p_roll_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_discard_bad_receive_data && !i_msg.msg_end) |-> !ev[`BTIC_IRQ_CBUF];
  endproperty
  a_roll_hold: assert property (p_roll_hold) else $error("rollover early");
  property p_roll_need;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (!i_enh_mem_rt && !roll_pend_q) |-> !ev[`BTIC_IRQ_CBUF];
  endproperty
  a_roll_need: assert property (p_roll_need) else $error("rollover not enabled");
  property p_rt_eom;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && mode == btic_pkg::BTIC_MODE_RT && !i_msg.cmd_invalid
       && i_enh_mem_rt && i_msg.sa_eom_en) |=> stat_q[`BTIC_IRQ_CWEOM];
  endproperty
  a_rt_eom: assert property (p_rt_eom) else $error("rt eom lost");
  property p_frame_cnt;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && mode == btic_pkg::BTIC_MODE_BC && !i_enhanced
       && i_msg.msg_count == 16'hffff && !i_msg.bc_abort) |=> stat_q[`BTIC_IRQ_FRAME];
  endproperty
  a_frame_cnt: assert property (p_frame_cnt) else $error("frame end lost");
  property p_ftimer;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_BC && i_enhanced && i_frame_timer_irq_en
       && i_msg.frame_timer_zero) |=> stat_q[`BTIC_IRQ_FRAME];
  endproperty
  a_ftimer: assert property (p_ftimer) else $error("frame timer lost");
  property p_loop;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (loop_fail && mode == btic_pkg::BTIC_MODE_BC) |=> stat_q[`BTIC_IRQ_FMT];
  endproperty
  a_loop: assert property (p_loop) else $error("loop failure lost");
  property p_msg_err;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && i_msg.msg_err && mode == btic_pkg::BTIC_MODE_BC)
      |=> stat_q[`BTIC_IRQ_FMT];
  endproperty
  a_msg_err: assert property (p_msg_err) else $error("message error lost");
  property p_rt_cmd;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && mode == btic_pkg::BTIC_MODE_RT && i_msg.cmd_invalid
       && !loop_fail && !resp_to) |-> !ev[`BTIC_IRQ_FMT];
  endproperty
  a_rt_cmd: assert property (p_rt_cmd) else $error("bad command flagged");
  property p_resp;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (resp_to && mode == btic_pkg::BTIC_MODE_BC) |=> stat_q[`BTIC_IRQ_FMT];
  endproperty
  a_resp: assert property (p_resp) else $error("timeout lost");
  property p_sts_addr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_BC && i_sts.sts_valid && i_sts.sts_addr != i_rt_addr)
      |=> stat_q[`BTIC_IRQ_SSET];
  endproperty
  a_sts_addr: assert property (p_sts_addr) else $error("status set lost");
  property p_bcst;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_BC && i_sts.sts_valid && i_sts.sts_addr == i_rt_addr
       && !i_enhanced && i_sts.bcst_mask && i_sts.sts_bits == 8'h10
       && !stat_q[`BTIC_IRQ_SSET] && !i_wr) |=> !stat_q[`BTIC_IRQ_SSET];
  endproperty
  a_bcst: assert property (p_bcst) else $error("broadcast bit not expected");
  property p_mcode;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_msg.msg_end && mode == btic_pkg::BTIC_MODE_RT && !i_msg.cmd_invalid && i_enhanced
       && i_mode_code_handling && i_msg.mode_code_en) |=> stat_q[`BTIC_IRQ_SSET];
  endproperty
  a_mcode: assert property (p_mcode) else $error("mode code lost");
  property p_trig;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (mode == btic_pkg::BTIC_MODE_MT && !cfg_q[12] && i_enhanced && i_msg.cmd_valid
       && i_msg.cmd_word == i_trigger_word) |=> stat_q[`BTIC_IRQ_SSET];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger lost");
  property p_ro_flag;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && i_addr == `BTIC_CFG1_ADDR && mode == btic_pkg::BTIC_MODE_BC)
      |=> o_rdata[`BTIC_EN_FLAG] == $past(busy);
  endproperty
  a_ro_flag: assert property (p_ro_flag) else $error("enable flag wrong");
  property p_irq_on;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (|(stat_d & mask_d)) |=> o_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  c_ttag: cover property (@(posedge i_mclk) ev[`BTIC_IRQ_TTAG]);
  c_fmt: cover property (@(posedge i_mclk) ev[`BTIC_IRQ_FMT]);
  c_irq: cover property (@(posedge i_mclk) o_irq);
endmodule : btic_top

// file: sim/btic_bus_model.sv
`timescale 1ns/100ps
module btic_bus_model (
  input wire logic i_mclk,
  output btic_pkg::btic_msg_t o_msg,
  output btic_pkg::btic_loop_t o_loop,
  output btic_pkg::btic_sts_t o_sts,
  output logic o_tick
);
  initial begin
    o_msg = '0;
    o_loop = '0;
    o_sts = '0;
    o_tick = 1'b0;
  end
  // message strobes last one cycle; ticks holds the tick n cycles and the block counts each sampled cycle
  task automatic send(input btic_pkg::btic_msg_t m);
    @(posedge i_mclk) o_msg <= m;
    @(posedge i_mclk) o_msg <= '0;
  endtask : send
  task automatic ticks(input int n);
    @(posedge i_mclk) o_tick <= 1'b1;
    repeat (n - 1) @(posedge i_mclk);
    @(posedge i_mclk) o_tick <= 1'b0;
  endtask : ticks
endmodule : btic_bus_model

// file: sim/test_btic_top.sv
`timescale 1ns/100ps
module test_btic_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ctrl_active = 1'b0;
  logic rs = 1'b0;
  // config levels: enh, mem, discard, wide, ftimer, bmask, mcode, alt, nrt
  logic [9:0] lv = 10'h000;
  logic [15:0] o_rdata;
  logic i_tick;
  btic_pkg::btic_msg_t i_msg;
  btic_pkg::btic_loop_t i_loop;
  btic_pkg::btic_sts_t i_sts;
  btic_pkg::btic_mode_t o_mode;
  logic o_area_b;
  logic [6:0] o_status;
  logic o_irq;
  logic [15:0] cfg = 16'h0000;
  logic [15:0] seed = 16'h003f;
  logic [15:0] r;
  logic [6:0] msk = 7'h7f;
  logic bot = 1'b0;
  btic_pkg::btic_msg_t m;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 i_mclk = ~i_mclk;
  btic_bus_model bus (
    .i_mclk(i_mclk),
    .o_msg(i_msg),
    .o_loop(i_loop),
    .o_sts(i_sts),
    .o_tick(i_tick)
  );
  btic_top dut (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_enhanced(lv[0]),
    .i_enh_mem_rt(lv[1]),
    .i_discard_bad_receive_data(lv[2]),
    .i_wide_controller_word_en(lv[3]),
    .i_frame_timer_irq_en(lv[4]),
    .i_bcst_mask_xor_n(lv[5]),
    .i_mode_code_handling(lv[6]),
    .i_nrt_sel(lv[9:8]),
    .i_alt_status(lv[7]),
    .i_ttag_tick(i_tick),
    .i_msg(i_msg),
    .i_loop(i_loop),
    .i_sts(i_sts),
    .i_rt_addr(seed[4:0]),
    .i_trigger_word(seed),
    .i_resp_start(rs),
    .i_resp_seen(1'b0),
    .i_ctrl_active(i_ctrl_active),
    .o_mode(o_mode),
    .o_area_b(o_area_b),
    .o_status(o_status),
    .o_irq(o_irq)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a == 8'h01) cfg = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  function automatic logic [6:0] model(input btic_pkg::btic_msg_t x);
    logic [6:0] e;
    e = {6'h00, x.msg_end};
    e[2] = x.msg_end && x.msg_err;
    if (cfg[15:14] == 2'b00 && x.msg_end) begin
      e[3] = x.msg_count == 16'hffff && !x.bc_abort && !lv[0];
      e[4] = lv[3] && x.bc_cw_eom;
    end
    if (cfg[15:14] == 2'b10 && lv[0] && lv[1]) begin
      e[4] = x.msg_end && x.sa_eom_en;
      if (x.cbuf_roll_en && !lv[2]) e[5] = x.cbuf_bottom;
      if (x.cbuf_roll_en && lv[2])
        e[5] = x.msg_end && (x.cbuf_bottom || bot) && !(x.msg_rx && x.msg_err);
    end
    return e;
  endfunction : model
  task automatic ev(input btic_pkg::btic_msg_t x);
    logic [6:0] e;
    e = model(x);
    bot = x.msg_end ? 1'b0 : bot | x.cbuf_bottom;
    wr(8'h03, 16'h007f);
    bus.send(x);
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_status, e);
    chk(o_irq, |(e & msk));
  endtask : ev
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // a hang counts as a mismatch
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk(o_mode, 16'h0000);
    rd(8'h01, r);
    chk(r, 16'h0000);
    rd(8'h7e, r);
    chk(r, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(8'h01, seed);
      rd(8'h01, r);
      chk(r, seed & 16'hfff8);
      chk(o_mode, seed[15:14]);
      chk(o_area_b, seed[13]);
    end
    wr(8'h01, 16'h3ffc);
    i_ctrl_active <= 1'b1;
    rd(8'h01, r);
    chk(r, 16'h3ffc);
    i_ctrl_active <= 1'b0;
    lv[0] = 1'b1;
    lv[7] = 1'b1;
    wr(8'h01, 16'h8ffc);
    rd(8'h01, r);
    chk(r, 16'h8ffc);
    lv[0] = 1'b0;
    lv[7] = 1'b0;
    $display("test config done");
    wr(8'h02, 16'h007f);
    wr(8'h01, 16'h0000);
    m = '0;
    m.msg_end = 1'b1;
    ev(m);
    m.msg_err = 1'b1;
    ev(m);
    m.msg_err = 1'b0;
    m.msg_count = 16'hffff;
    ev(m);
    m.bc_abort = 1'b1;
    ev(m);
    m = '0;
    m.msg_end = 1'b1;
    m.bc_cw_eom = 1'b1;
    lv[3] = 1'b1;
    ev(m);
    lv[3] = 1'b0;
    ev(m);
    // enhanced mode on; masking bit 0 only gates the request
    lv[0] = 1'b1;
    msk = 7'h7e;
    wr(8'h02, 16'h007e);
    ev(m);
    $display("test controller events done");
    lv[1] = 1'b1;
    wr(8'h01, 16'h8000);
    m = '0;
    m.cbuf_roll_en = 1'b1;
    m.cbuf_bottom = 1'b1;
    ev(m);
    lv[1] = 1'b0;
    ev(m);
    lv[1] = 1'b1;
    lv[2] = 1'b1;
    ev(m);
    m.cbuf_bottom = 1'b0;
    m.msg_end = 1'b1;
    ev(m);
    m.cbuf_bottom = 1'b1;
    m.msg_rx = 1'b1;
    m.msg_err = 1'b1;
    ev(m);
    m = '0;
    m.msg_end = 1'b1;
    m.sa_eom_en = 1'b1;
    ev(m);
    $display("test terminal events done");
    wr(8'h03, 16'h007f);
    @(posedge i_mclk) rs <= 1'b1;
    @(posedge i_mclk) rs <= 1'b0;
    repeat (2200) @(posedge i_mclk);
    #1;
    chk(o_status, 16'h0000);
    repeat (200) @(posedge i_mclk);
    #1;
    chk(o_status, 16'h0004);
    $display("test timeout done");
    wr(8'h03, 16'h007f);
    bus.ticks(65535);
    rd(8'h04, r);
    chk(r, 16'hffff);
    chk(o_status, 16'h0000);
    bus.ticks(1);
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_status, 16'h0040);
    chk(o_irq, 16'h0001);
    rd(8'h04, r);
    chk(r, 16'h0000);
    $display("test time tag done");
    tally_and_finish();
  end
endmodule : test_btic_top
